// file: hw/stas_pkg.sv
package stas_pkg;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
  localparam logic [7:0] OFS_TEMP_DATA = 8'h27;
  localparam logic [7:0] OFS_HOT_THRESHOLD = 8'h39;
  localparam logic [7:0] OFS_INT_STATUS = 8'h41;
  localparam logic [7:0] OFS_INT_MASK = 8'h43;
  localparam logic [7:0] OFS_TEMP_CONFIG = 8'h4b;
  localparam logic [7:0] HOT_RESET = 8'h50;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] TCONF_RESET = 2'h0;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [1:0] MODE_COMPARATOR = 2'h2;
  localparam int TEMP_BIT = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_CMD = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_RACK = 5'h10
  } stas_state_t;
endpackage

// file: hw/stas_slave.sv
`timescale 1ns/10ps
// Function
// - Comparator mode flags conversions at/above hot threshold.
// - Comparator mode holds alert while temperature at/above threshold.
// - Comparator-mode status read leaves alert and status bit.
// - Interrupt regenerated each conversion until cooler.
// - Threshold, mask and temperature registers are byte-wide; config keeps two bits, status one bit.
// - Only five SMBus transaction types supported.
// - Temperature mask suppresses status bit and alert.
// - Alert response address returns own address.
// - Alert response query does not clear alert.
module stas_slave
  import stas_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = stas_pkg::DEV_ADDR_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic alert_o,
  output logic alert_oe_o,
  input wire logic conv_done_i,
  input wire logic [7:0] temp_i
);
  import stas_pkg::*;

  logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  stas_state_t st;
  logic [7:0] shreg, txsh, ptr;
  logic [3:0] bits;
  logic [1:0] idx;
  logic rw, ara, nack, sda_oe;
  logic [7:0] hot_temp_threshold, int_mask, temp_data;
  logic [1:0] temp_mode;
  logic stat_temp, alert_act, over_now, comparator;
  logic byte_done, addr_hit, ara_hit, wr_stb, rd_load, stat_rd;
  logic [7:0] rd_data;

  // Pins come from the host clock domain
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_q;
  assign scl_fall = ~scl_s2 & scl_q;
  assign start_det = scl_s2 & scl_q & sda_q & ~sda_s2;
  assign stop_det = scl_s2 & scl_q & ~sda_q & sda_s2;

  assign comparator = (temp_mode == MODE_COMPARATOR);
  assign over_now = $signed(temp_i) >= $signed(hot_temp_threshold);
  assign alert_act = stat_temp & ~int_mask[TEMP_BIT];
  assign byte_done = (st == ST_RX) & scl_fall & (bits == BITS_PER_BYTE);
  assign addr_hit = shreg[7:1] == DEV_ADDR;
  assign ara_hit = (shreg[7:1] == ARA_ADDR) & shreg[0] & alert_act;
  assign wr_stb = byte_done & (idx == IDX_DATA) & ~rw;
  assign rd_load = scl_fall & (((st == ST_ACK) & rw) |
                   ((st == ST_RACK) & ~nack));
  assign stat_rd = rd_load & ~ara & (ptr == OFS_INT_STATUS);

  always_comb
  begin
    case (ptr)
      OFS_TEMP_DATA: rd_data = temp_data;
      OFS_HOT_THRESHOLD: rd_data = hot_temp_threshold;
      OFS_INT_STATUS: rd_data = {3'h0, alert_act, 4'h0};
      OFS_INT_MASK: rd_data = int_mask;
      OFS_TEMP_CONFIG: rd_data = {6'h00, temp_mode};
      default: rd_data = 8'h00;
    endcase
  end

  // Protocol engine; a start always wins, so repeated start reenters
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= ST_IDLE;
      shreg <= 8'h00;
      txsh <= 8'h00;
      ptr <= 8'h00;
      bits <= 4'h0;
      idx <= IDX_ADDR;
      rw <= 1'b0;
      ara <= 1'b0;
      nack <= 1'b1;
    end
    else if (start_det)
    begin
      st <= ST_RX;
      bits <= 4'h0;
      idx <= IDX_ADDR;
      ara <= 1'b0;
    end
    else if (stop_det)
      st <= ST_IDLE;
    else
    begin
      case (st)
        ST_RX:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s2};
            bits <= bits + 4'h1;
          end
          if (byte_done)
          begin
            bits <= 4'h0;
            if (idx != IDX_ADDR)
            begin
              st <= ST_ACK;
              if (idx == IDX_CMD)
                ptr <= shreg;
            end
            else if (addr_hit | ara_hit)
            begin
              st <= ST_ACK;
              rw <= shreg[0];
              ara <= ~addr_hit;
            end
            else
              st <= ST_IDLE;
          end
        end
        ST_ACK:
          if (scl_fall)
          begin
            if (idx != IDX_DATA)
              idx <= idx + 2'h1;
            st <= rw ? ST_TX : ST_RX;
          end
        ST_TX:
          if (scl_fall)
          begin
            txsh <= {txsh[6:0], 1'b0};
            bits <= bits + 4'h1;
            if (bits == LAST_TX_BIT)
              st <= ST_RACK;
          end
        ST_RACK:
        begin
          if (scl_rise)
            nack <= sda_s2;
          if (scl_fall)
          begin
            bits <= 4'h0;
            st <= nack ? ST_IDLE : ST_TX;
          end
        end
        default: st <= ST_IDLE;
      endcase
      // Read word walks to the next register for its second byte
      if (rd_load)
      begin
        txsh <= ara ? {DEV_ADDR, 1'b1} : rd_data;
        if (!ara)
          ptr <= ptr + 8'h01;
      end
    end
  end

  // Registered so the data line never glitches on a decode change
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sda_oe <= 1'b0;
    else
      sda_oe <= (st == ST_ACK) | ((st == ST_TX) & ~txsh[7]);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hot_temp_threshold <= HOT_RESET;
      int_mask <= MASK_RESET;
      temp_mode <= TCONF_RESET;
    end
    else if (wr_stb)
    begin
      case (ptr)
        OFS_HOT_THRESHOLD: hot_temp_threshold <= shreg;
        OFS_INT_MASK: int_mask <= shreg;
        OFS_TEMP_CONFIG: temp_mode <= shreg[1:0];
        default: ;
      endcase
    end
  end

  // Fault state; in latched modes a new fault beats the read clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      temp_data <= TEMP_RESET;
      stat_temp <= 1'b0;
    end
    else
    begin
      if (conv_done_i)
        temp_data <= temp_i;
      if (comparator)
      begin
        if (conv_done_i)
          stat_temp <= over_now;
      end
      else if (conv_done_i & over_now)
        stat_temp <= 1'b1;
      else if (stat_rd)
        stat_temp <= 1'b0;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe;
  assign alert_o = 1'b0;
  assign alert_oe_o = alert_act;

  sequence s_addr_mine;
    byte_done && idx == IDX_ADDR && addr_hit && !start_det && !stop_det;
  endsequence
  sequence s_ara_query;
    byte_done && idx == IDX_ADDR && ara_hit && !addr_hit
      && !start_det && !stop_det;
  endsequence

  // A mask write in the same cycle may legally hide the new fault
  a_cmp_raise: assert property (@(posedge clk_i)
    disable iff (rst_i)
    comparator && conv_done_i && over_now && !int_mask[TEMP_BIT]
      && !wr_stb |=> alert_oe_o)
    else $error("comparator fault did not raise alert");
  a_cmp_release: assert property (@(posedge clk_i)
    disable iff (rst_i) comparator && conv_done_i && !over_now
    |=> !alert_oe_o)
    else $error("alert not released below threshold");
  a_cmp_hold: assert property (@(posedge clk_i)
    disable iff (rst_i)
    comparator && !conv_done_i && !wr_stb |=> $stable(alert_oe_o))
    else $error("alert changed without a conversion");
  a_read_keeps: assert property (@(posedge clk_i)
    disable iff (rst_i)
    comparator && stat_rd && !conv_done_i |=> $stable(stat_temp))
    else $error("status read cleared comparator fault");
  a_mask_gate: assert property (@(posedge clk_i)
    disable iff (rst_i) int_mask[TEMP_BIT] |-> !alert_oe_o)
    else $error("masked fault drove alert");
  a_addr_ack: assert property (@(posedge clk_i)
    disable iff (rst_i) s_addr_mine |=> st == ST_ACK ##1 sda_oe_o)
    else $error("own address not acknowledged");
  a_ara_reply: assert property (@(posedge clk_i)
    disable iff (rst_i) s_ara_query |=> ara && st == ST_ACK)
    else $error("alert response query not answered");
  a_ara_keeps: assert property (@(posedge clk_i)
    disable iff (rst_i)
    rd_load && ara && !conv_done_i |=> alert_oe_o == $past(alert_oe_o))
    else $error("alert response cleared alert");
  a_nack_end: assert property (@(posedge clk_i)
    disable iff (rst_i) st == ST_RACK && scl_fall && nack
    && !start_det && !stop_det |=> st == ST_IDLE)
    else $error("read not ended by host nack");
  a_hot_write: assert property (@(posedge clk_i)
    disable iff (rst_i) wr_stb && ptr == OFS_HOT_THRESHOLD
    |=> hot_temp_threshold == $past(shreg))
    else $error("threshold write lost");
endmodule

// file: test/stas_host_model.sv
`timescale 1ns/10ps
module stas_host_model
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic ph(input logic s, input logic d, input int n);
    @(posedge clk_i);
    scl_o <= s;
    sda_low_o <= d;
    repeat (n - 1) @(posedge clk_i);
  endtask

  // SDA only moves while SCL is low, MSB first
  task automatic xbyte(input logic [7:0] tx, input logic mack,
    output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      ph(1'b0, sda_low_o, 2);
      ph(1'b0, ~tx[i], 2);
      ph(1'b1, ~tx[i], 3);
      rx[i] = sda_i;
      ph(1'b1, ~tx[i], 1);
    end
    ph(1'b0, sda_low_o, 2);
    ph(1'b0, mack, 2);
    ph(1'b1, mack, 3);
    ack = ~sda_i;
    ph(1'b1, mack, 1);
  endtask

  // Long low phase so a slave acknowledge is gone before SCL rises
  task automatic start;
    ph(1'b0, 1'b0, 6);
    ph(1'b1, 1'b0, 4);
    ph(1'b1, 1'b1, 4);
  endtask

  task automatic stop;
    ph(1'b0, 1'b1, 2);
    ph(1'b1, 1'b1, 4);
    ph(1'b1, 1'b0, 4);
  endtask
endmodule

// file: test/stas_slave_tb.sv
`timescale 1ns/10ps
module stas_slave_tb;
  import stas_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic conv_done_i = 1'b0;
  logic [7:0] temp_i = 8'h00;
  logic scl, low, sda_o, sda_oe_o, alert_o, alert_oe_o, sda, a, aa;
  logic [7:0] d, e;
  int n_fail = 0;
  int tests_run = 0;
  localparam logic [6:0] DA = DEV_ADDR_DEFAULT;

  always #25 clk_i = ~clk_i;
  // Open-drain wire with pull-up
  assign sda = ~(low | sda_oe_o);

  stas_host_model h (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(low));
  stas_slave dut_u (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alert_o(alert_o),
    .alert_oe_o(alert_oe_o), .conv_done_i(conv_done_i), .temp_i(temp_i));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrb(input logic [7:0] c, input logic [7:0] v);
    h.start();
    h.xbyte({DA, 1'b0}, 1'b0, e, aa);
    h.xbyte(c, 1'b0, e, a);
    h.xbyte(v, 1'b0, e, a);
    h.stop();
  endtask

  task automatic rdb(input logic [7:0] c, input logic two);
    h.start();
    h.xbyte({DA, 1'b0}, 1'b0, e, aa);
    h.xbyte(c, 1'b0, e, a);
    h.start();
    h.xbyte({DA, 1'b1}, 1'b0, e, aa);
    h.xbyte(8'hff, two, d, a);
    if (two)
      h.xbyte(8'hff, 1'b0, e, a);
    h.stop();
  endtask

  task automatic rcv(input logic [6:0] ad);
    h.start();
    h.xbyte({ad, 1'b1}, 1'b0, e, aa);
    h.xbyte(8'hff, 1'b0, d, a);
    h.stop();
  endtask

  task automatic conv(input logic [7:0] t);
    @(posedge clk_i);
    conv_done_i <= 1'b1;
    temp_i <= t;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_regs;
    wrb(OFS_HOT_THRESHOLD, 8'h30);
    chk({7'h00, aa}, 8'h01);
    chk({7'h00, a}, 8'h01);
    rdb(OFS_HOT_THRESHOLD, 1'b0);
    chk(d, 8'h30);
    rdb(OFS_HOT_THRESHOLD, 1'b1);
    chk(d, 8'h30);
    chk(e, 8'h00);
    h.start();
    h.xbyte({DA, 1'b0}, 1'b0, e, a);
    h.xbyte(OFS_HOT_THRESHOLD, 1'b0, e, a);
    h.stop();
    rcv(DA);
    chk(d, 8'h30);
    chk({7'h00, aa}, 8'h01);
    rcv(DA ^ 7'h01);
    chk({7'h00, aa}, 8'h00);
    chk(d, 8'hff);
    chk({6'h00, sda_o, alert_o}, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_cmp;
    wrb(OFS_TEMP_CONFIG, {6'h00, MODE_COMPARATOR});
    conv(8'h30);
    chk({7'h00, alert_oe_o}, 8'h01);
    rdb(OFS_INT_STATUS, 1'b0);
    chk(d & 8'h10, 8'h10);
    chk({7'h00, alert_oe_o}, 8'h01);
    conv(8'h45);
    chk({7'h00, alert_oe_o}, 8'h01);
    rcv(ARA_ADDR);
    chk(d, {DA, 1'b1});
    chk({7'h00, alert_oe_o}, 8'h01);
    conv(8'hf0);
    chk({7'h00, alert_oe_o}, 8'h00);
    $display("test comparator done");
  endtask

  task automatic t_mask;
    wrb(OFS_INT_MASK, 8'h10);
    conv(8'h60);
    chk({7'h00, alert_oe_o}, 8'h00);
    rdb(OFS_INT_STATUS, 1'b0);
    chk(d & 8'h10, 8'h00);
    rcv(ARA_ADDR);
    chk({7'h00, aa}, 8'h00);
    chk(d, 8'hff);
    $display("test mask done");
  endtask

  // Latched mode: the status read is what clears the alert
  task automatic t_dflt;
    wrb(OFS_INT_MASK, 8'h00);
    wrb(OFS_TEMP_CONFIG, 8'h00);
    conv(8'h60);
    chk({7'h00, alert_oe_o}, 8'h01);
    rdb(OFS_INT_STATUS, 1'b0);
    chk(d & 8'h10, 8'h10);
    chk({7'h00, alert_oe_o}, 8'h00);
    $display("test default mode done");
  endtask

  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_regs();
    t_cmp();
    t_mask();
    t_dflt();
    end_sim();
  end

  // Whole run is near 3800 cycles
  initial
  begin
    #2ms;
    n_fail++;
    end_sim();
  end
endmodule
